// ===== tcc_timer.sv
`timescale 1ns/1ps
module tcc_timer
  import tcc_pkg::*;
#(
  parameter int DIV_RATIO = DIV32_RATIO
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] count_clock_sel,
  input wire logic [1:0] capture_edge_sel,
  input wire logic inversion_control_bit,
  input wire logic output_enable_bit,
  input wire logic match_irq_mask,
  input wire logic match_irq_flag_clr,
  input wire logic overflow_flag_clr,
  input wire logic [15:0] compare_value_in,
  input wire logic compare_lo_we,
  input wire logic compare_hi_we,
  input wire logic count_lo_rd,
  input wire logic count_hi_rd,
  input wire logic capture_trigger_pin,
  input wire logic port_latch,
  output logic shared_port_pin,
  output logic [15:0] compare_value_reg,
  output logic [15:0] capture_value_reg,
  output logic [15:0] count_read_data,
  output logic match_interrupt,
  output logic match_irq_flag,
  output logic overflow_flag,
  output logic toggle_output
);
  // *************************************************
  // checks and local state
  // *************************************************
  // divider counts in 8 bits and needs at least two phases
  if (DIV_RATIO < 2 || DIV_RATIO > 256) begin : g_bad_div
    $error("DIV_RATIO out of range");
  end

  // divider end count and half a count clock, both in system clocks
  localparam logic [7:0] DIV_LAST = 8'(DIV_RATIO - 1);
  localparam logic [7:0] DIV_HALF = 8'(DIV_RATIO / 2);

  // counter, prescaler, irq window and strobe history
  logic [15:0] free_run_counter;
  logic [7:0] div_cnt;
  logic [7:0] irq_hold;
  logic buf_held;
  logic lo_rd_d;
  logic hi_rd_d;
  logic oe_d;
  logic inv_d;
  tcc_cap_if cap ();
  // next values, decoded by the assignments beside each process
  logic next_match_flag;
  logic next_ovf_flag;
  logic [7:0] next_irq_hold;
  logic next_irq;
  logic next_toggle;
  logic next_pin;
  logic [15:0] next_read_data;
  logic [15:0] next_capture;

  // *************************************************
  // count clock and match decode
  // *************************************************
  // prohibited codes stall the counter rather than run at a guessed rate
  wire div_tick = (div_cnt == DIV_LAST);
  wire count_tick = (count_clock_sel == CLK_SEL_MAIN) ||
                    ((count_clock_sel == CLK_SEL_DIV32) && div_tick);
  wire match_now = count_tick && (free_run_counter == compare_value_reg);
  // overflow is the tick that leaves all ones
  wire wrap_now = count_tick && (free_run_counter == 16'hffff);
  // strobe and enable edges from last cycle's copies
  wire lo_rise = count_lo_rd & ~lo_rd_d;
  wire hi_fall = ~count_hi_rd & hi_rd_d;
  wire oe_rise = output_enable_bit & ~oe_d;
  // half a count clock in system clocks; main clock mode gives one cycle
  wire [7:0] half_len = (count_clock_sel == CLK_SEL_DIV32) ? DIV_HALF : 8'h01;
  // a steady enable flips once per match, keeping a clean square wave;
  // only a fresh enable inside the high window adds the extra flip
  wire inv_rise = inversion_control_bit & ~inv_d;
  wire invert_now = (inversion_control_bit && match_now) ||
                    (inv_rise && irq_hold != 8'h00);

  // edge select passes straight through to the detector
  assign cap.edge_sel = capture_edge_sel;

  // synchronizer and edge decode live in their own module
  tcc_edge_detect u_edge (
    .clock(clock),
    .rst_n(rst_n),
    .pin_raw(capture_trigger_pin),
    .cap(cap)
  );

  // *************************************************
  // counter and prescaler
  // *************************************************
  // counter never clears on match, only wraps
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      free_run_counter <= COUNT_RESET;
      div_cnt <= 8'h00;
    end else begin
      // prescaler free-runs, so a mode change may land on any phase
      div_cnt <= div_tick ? 8'h00 : div_cnt + 8'h01;
      if (count_tick) begin
        free_run_counter <= free_run_counter + 16'h0001;
      end
    end
  end

  // *************************************************
  // compare register, flags and interrupt
  // *************************************************
  // byte writes land independently; sequencing is software's duty
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      compare_value_reg <= 16'h0000;
    end else begin
      if (compare_lo_we) begin
        compare_value_reg[7:0] <= compare_value_in[7:0];
      end
      if (compare_hi_we) begin
        compare_value_reg[15:8] <= compare_value_in[15:8];
      end
    end
  end

  // set wins over clear for both sticky flags
  assign next_match_flag = match_now | (match_irq_flag & ~match_irq_flag_clr);
  assign next_ovf_flag = wrap_now | (overflow_flag & ~overflow_flag_clr);
  // window reloads on each match, otherwise runs down to zero and rests
  assign next_irq_hold = match_now ? half_len :
                         (irq_hold != 8'h00) ? irq_hold - 8'h01 : 8'h00;
  // mask gates only the request line, the flag still records the match
  assign next_irq = (match_now || irq_hold > 8'h01) && !match_irq_mask;

  // sticky match and overflow flags
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      match_irq_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      match_irq_flag <= next_match_flag;
      overflow_flag <= next_ovf_flag;
    end
  end

  // interrupt line and its high window
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_hold <= 8'h00;
      match_interrupt <= 1'b0;
    end else begin
      irq_hold <= next_irq_hold;
      match_interrupt <= next_irq;
    end
  end

  // *************************************************
  // toggle output and shared pin
  // *************************************************
  // enable edge forces low first, otherwise each inversion flips the level
  assign next_toggle = oe_rise ? 1'b0 : toggle_output ^ invert_now;
  // pin shows the new level on the same edge as the flip, not one later
  assign next_pin = output_enable_bit ? next_toggle : port_latch;

  // toggle state, enable history and the registered pin
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      toggle_output <= 1'b0;
      oe_d <= 1'b0;
      inv_d <= 1'b0;
      shared_port_pin <= 1'b0;
    end else begin
      toggle_output <= next_toggle;
      oe_d <= output_enable_bit;
      inv_d <= inversion_control_bit;
      shared_port_pin <= next_pin;
    end
  end

  // *************************************************
  // capture register
  // *************************************************
  // capture only on a decoded edge, otherwise hold until the next one
  assign next_capture = cap.edge_hit ? free_run_counter : capture_value_reg;
  // software must stop edges while reading, a hit overwrites the value
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      capture_value_reg <= 16'h0000;
    end else begin
      capture_value_reg <= next_capture;
    end
  end

  // *************************************************
  // counter read buffer
  // *************************************************
  // frozen from the strobe edge on, so the value of the edge before is kept
  assign next_read_data = (!buf_held && !lo_rise) ? free_run_counter : count_read_data;
  // a lone low read leaves the buffer held until a high read ends
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lo_rd_d <= 1'b0;
      hi_rd_d <= 1'b0;
      buf_held <= 1'b0;
      count_read_data <= COUNT_RESET;
    end else begin
      lo_rd_d <= count_lo_rd;
      hi_rd_d <= count_hi_rd;
      if (lo_rise) begin
        buf_held <= 1'b1;
      end else if (hi_fall) begin
        buf_held <= 1'b0;
      end
      count_read_data <= next_read_data;
    end
  end
endmodule : tcc_timer

// ===== tcc_pkg.sv
// What this block does
// - on compare match with inversion enabled, toggle the timer output level
// - on match counter keeps counting; match interrupt request is raised
// - toggle output starts low when output is first enabled
// - capture loads count within 3 clocks of edge, holds until next edge
// - edge select: 00 off, 01 rising, 10 falling, 11 both edges
// - read buffer tracks count, freezes after low-byte read strobe rises
// - read buffer resumes tracking after high-byte read strobe falls
// - reset clears counter to zero, then it free-runs again
// - byte reads come low then high; lone low read keeps buffer held
// - counter keeps counting after stop release, so its value is undefined
// - a compare rewrite may double the interval or distort the waveform
// - match interrupt stays high half a count clock after generation; one clock in main clock mode
// - clock select 00 main clock, 01 main clock divided by 32, else prohibited
// - overflow flag set on counter overflow, cleared by reset or software
// - output enable 0 gives port pin; 1 carries timer output
package tcc_pkg;
  localparam int CNT_W = 16;
  localparam logic [1:0] CLK_SEL_MAIN = 2'h0;
  localparam logic [1:0] CLK_SEL_DIV32 = 2'h1;
  localparam int DIV32_RATIO = 32;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
endpackage : tcc_pkg

// ===== tcc_cap_if.sv
`timescale 1ns/1ps
// capture path signals between the top and the edge detector
interface tcc_cap_if;
  logic [1:0] edge_sel;
  logic       edge_hit;
  modport detector (input edge_sel, output edge_hit);
  modport owner (output edge_sel, input edge_hit);
endinterface : tcc_cap_if

// ===== tcc_edge_detect.sv
`timescale 1ns/1ps
module tcc_edge_detect
  import tcc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pin_raw,
  tcc_cap_if.detector cap
);
  logic sync_a;
  logic sync_b;
  logic prev;
  wire rise = sync_b & ~prev;
  wire fall = ~sync_b & prev;
  wire hit_rise = (cap.edge_sel == EDGE_RISE) && rise;
  wire hit_fall = (cap.edge_sel == EDGE_FALL) && fall;
  wire hit_both = (cap.edge_sel == EDGE_BOTH) && (rise || fall);

  // two-stage synchronizer, edge logic reads only the second stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  // edge code 00 never hits, so capture is off
  assign cap.edge_hit = hit_rise | hit_fall | hit_both;
endmodule : tcc_edge_detect

// ===== tcc_sva.sv
`timescale 1ns/1ps
module tcc_sva
  import tcc_pkg::*;
#(
  parameter int DIV_RATIO = DIV32_RATIO
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] count_clock_sel,
  input wire logic inversion_control_bit,
  input wire logic output_enable_bit,
  input wire logic match_irq_mask,
  input wire logic overflow_flag_clr,
  input wire logic count_lo_rd,
  input wire logic count_hi_rd,
  input wire logic port_latch,
  input wire logic shared_port_pin,
  input wire logic [15:0] count_read_data,
  input wire logic match_interrupt,
  input wire logic match_irq_flag,
  input wire logic overflow_flag,
  input wire logic toggle_output
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // low read seen on two edges, so the freeze has surely landed
  sequence lo_held;
    count_lo_rd ##1 count_lo_rd;
  endsequence
  // reset check must not be disabled by the reset it watches
  AST_RST_CLEAR: assert property (disable iff (1'b0) !rst_n [*2] |->
    count_read_data == COUNT_RESET && !overflow_flag && !match_irq_flag) else $error("reset");
  AST_BUF_HOLD: assert property (lo_held |=> $stable(count_read_data))
    else $error("hold");
  AST_BUF_RESUME: assert property ($fell(count_hi_rd) && !count_lo_rd &&
    count_clock_sel == CLK_SEL_MAIN |-> ##[1:3] $changed(count_read_data)) else $error("resume");
  AST_IRQ_RAISE: assert property ($rose(match_irq_flag) && !$past(match_irq_mask) |->
    match_interrupt) else $error("irq");
  AST_IRQ_SHORT: assert property ($rose(match_interrupt) && count_clock_sel == CLK_SEL_MAIN
    |=> !match_interrupt) else $error("irq width");
  AST_TOGGLE: assert property ($rose(match_irq_flag) && $past(inversion_control_bit) &&
    $past(output_enable_bit, 2) |-> toggle_output != $past(toggle_output)) else $error("toggle");
  AST_OE_START: assert property ($rose(output_enable_bit) |=> !toggle_output &&
    !shared_port_pin) else $error("start low");
  AST_PIN_SEL: assert property ($past(rst_n) |-> shared_port_pin ==
    ($past(output_enable_bit) ? toggle_output : $past(port_latch))) else $error("pin");
  AST_OVF_STICKY: assert property ($past(rst_n) && $past(overflow_flag) &&
    !$past(overflow_flag_clr) |-> overflow_flag) else $error("overflow");
endmodule : tcc_sva
bind tcc_timer tcc_sva #(.DIV_RATIO(DIV_RATIO)) u_sva (.clock, .rst_n, .count_clock_sel,
  .inversion_control_bit, .output_enable_bit, .match_irq_mask, .overflow_flag_clr,
  .count_lo_rd, .count_hi_rd, .port_latch, .shared_port_pin, .count_read_data,
  .match_interrupt, .match_irq_flag, .overflow_flag, .toggle_output);

// ===== tcc_trig_model.sv
`timescale 1ns/1ps
module tcc_trig_model (
  input wire logic flip_req,
  output logic trig_pin
);
  // external source: idles low, flips a few ns off the clock grid
  initial begin
    trig_pin = 1'b0;
    forever @(flip_req) trig_pin <= #7 ~trig_pin;
  end
endmodule : tcc_trig_model

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tcc_pkg::*;
  localparam int DIV = 4;
  logic clock = 0, rst_n = 0, inv = 0, oe = 0, mask = 1, fclr = 0, oclr = 0, lwe = 0, hwe = 0;
  logic lrd = 0, hrd = 0, latch = 0, treq = 0, e = 0, trig, pin, flag, ovf, tog, irq;
  logic [1:0] sel = 0, esel = 0;
  logic [15:0] cin = 0, v, cap, rdd, cmp;
  int err_total = 0, total_checks = 0, n;
  tcc_trig_model u_trig (.flip_req(treq), .trig_pin(trig));
  tcc_timer #(.DIV_RATIO(DIV)) u_dut (.clock, .rst_n, .count_clock_sel(sel),
    .capture_edge_sel(esel), .inversion_control_bit(inv), .output_enable_bit(oe),
    .match_irq_mask(mask), .match_irq_flag_clr(fclr), .overflow_flag_clr(oclr),
    .compare_value_in(cin), .compare_lo_we(lwe), .compare_hi_we(hwe), .count_lo_rd(lrd),
    .count_hi_rd(hrd), .capture_trigger_pin(trig), .port_latch(latch), .shared_port_pin(pin),
    .compare_value_reg(cmp), .capture_value_reg(cap), .count_read_data(rdd),
    .match_interrupt(irq), .match_irq_flag(flag), .overflow_flag(ovf), .toggle_output(tog));
  initial begin
    forever #20 clock = ~clock;
  end
  task automatic tk(int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : tk
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // counts expected over 8*DIV cycles for each clock select code
  function automatic logic [15:0] steps(int c);
    return c == CLK_SEL_MAIN ? 16'(8 * DIV) : c == CLK_SEL_DIV32 ? 16'h8 : 16'h0;
  endfunction : steps
  // main sequence
  initial begin
    void'($urandom(48869));
    tk(4);
    rst_n = 1;
    chk(rdd, 16'h0);
    lrd = 1;
    tk(2);
    v = rdd;
    lrd = 0;
    tk(5);
    chk(rdd, v);
    hrd = 1;
    tk(1);
    hrd = 0;
    tk(3);
    v = rdd;
    tk(5);
    chk(rdd, v + 16'h5);
    for (int c = 3; c >= 0; c--) begin
      sel = 2'(c);
      tk(DIV);
      v = rdd;
      tk(8 * DIV);
      chk(rdd - v, steps(c));
    end
    $display("count and read done");
    oe = 1;
    tk(2);
    chk(tog, 16'h0);
    // compare rewrites: masked, inversion off, high byte then low, then clear flag;
    // the second pass writes the whole word and waits one count clock instead
    for (int i = 0; i < 3; i++) begin
      mask = 1;
      inv = 0;
      cin = i < 2 ? rdd + 16'(9 + $urandom_range(30)) : 16'hffff;
      hwe = 1;
      lwe = 1'(i == 1);
      tk(1);
      hwe = 0;
      lwe = 1'(i != 1);
      tk(1);
      lwe = 0;
      chk(cmp, cin);
      fclr = 1;
      tk(1);
      fclr = 0;
      mask = 0;
      inv = 1;
      n = 0;
      while (flag !== 1'b1 && n < 70000) begin
        tk(1);
        n++;
      end
      e = ~e;
      chk(flag, 16'h1);
      chk(tog, e);
      chk(irq, 16'h1);
      chk(pin, e);
      chk(ovf, i == 2);
      tk(1);
      chk(irq, 16'h0);
      chk(tog, e);
    end
    oclr = 1;
    tk(1);
    oclr = 0;
    tk(1);
    chk(ovf, 16'h0);
    $display("compare done");
    // two pin flips per edge mode; mode 00 must ignore both
    for (int s = 0; s < 4; s++) begin
      esel = 2'(s);
      n = 0;
      repeat (2) begin
        v = cap;
        treq = ~treq;
        tk(8);
        n += int'(cap !== v);
      end
      chk(16'(n), 16'(s[0] + s[1]));
    end
    $display("capture done");
    oe = 0;
    latch = 1'($urandom);
    tk(2);
    chk(pin, latch);
    latch = ~latch;
    tk(1);
    chk(pin, latch);
    $display("pin done");
    final_report();
  end
  // longest wait is one full counter wrap, about 66k cycles
  initial begin
    tk(90000);
    err_total++;
    final_report();
  end
endmodule : tb_top
